// ==== hdl/scs_defs.vh ====
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH
// Read pointer values (low three bits of the command byte)
`define SCS_PTR_STATUS 3'h0
`define SCS_PTR_SPECIAL 3'h1
`define SCS_PTR_VECTOR 3'h2
// Command field position and codes (bits 5:3 of the command byte)
`define SCS_CMD_HI 5
`define SCS_CMD_LO 3
`define SCS_CMD_RST_EXT 3'h2
// Underrun latch reset code (bits 7:6 of the command byte)
`define SCS_URUN_HI 7
`define SCS_URUN_LO 6
`define SCS_CMD_RST_URUN 2'h3
// Receive modes
`define SCS_MODE_ASYNC 2'h0
`define SCS_MODE_CHSYNC 2'h1
`define SCS_MODE_SDLC 2'h2
`define SCS_MODE_EXTSYNC 2'h3
// Channel status bit positions
`define SCS_B_RXAV 0
`define SCS_B_IP 1
`define SCS_B_TXE 2
`define SCS_B_DCD 3
`define SCS_B_HUNT 4
`define SCS_B_CTS 5
`define SCS_B_URUN 6
`define SCS_B_BRK 7
// Reset value of the channel status register
`define SCS_STATUS_RST 8'h44
// Abort threshold in consecutive ones
`define SCS_ABORT_ONES 4'h7
// Sync detect pulse hold count; output stays low this many core cycles after the pattern cycle
`define SCS_SYNC_PULSE 2'h2
`endif

// ==== hdl/scs_channel_status.v ====
`timescale 1ns/1ps
// Notes on behaviour
// - Non-primary registers need pointer write before read
// - Three status registers; vector only on second channel
// - Receive-available set while queue not empty
// - Interrupt pending on first channel, zero otherwise
// - Transmit empty, not during CRC, set at reset
// - Carrier bit latched at any external change
// - Latches follow live pins after reset command
// - Async: sync pin edges set/clear hunt bit
// - External sync: high pin keeps hunt cleared
// - Sync edges interrupt; hunt entry ignored in pin modes
// - Char sync: hunt entry sets, sync clears
// - Char sync: sync pin pulses low on pattern
// - SDLC: hunt set by hunt/disable, flag clears
// - Clear-to-send latch reports inverted pin
// - Underrun set at reset, cleared by own command
// - Break sets, end clears, rearm after reset command
// - One null character remains after break ends
// - SDLC abort on seven ones; unused byte-sync
// - Next external change waits for reset command
`include "scs_defs.vh"

module scs_channel_status #(
    parameter CHANNEL_B = 0
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_reset,
    // Host command and read port
    input wire i_cmd_wr,
    input wire [7:0] i_cmd_data,
    input wire i_rd,
    output reg [7:0] o_rd_data,
    // Neighbouring registers for pointer reads
    input wire [7:0] i_special_receive_status,
    input wire [7:0] i_vector_readback,
    // Configuration
    input wire [1:0] i_rx_mode,
    input wire i_rx_enable,
    input wire i_enter_hunt,
    // Receiver and transmitter events
    input wire i_rx_queue_nonempty,
    input wire i_tx_buf_empty,
    input wire i_tx_crc_sending,
    input wire i_tx_underrun,
    input wire i_sync_pattern,
    input wire i_flag_seen,
    input wire i_rx_bit_valid,
    input wire i_rx_bit,
    input wire i_break_char,
    input wire i_break_end,
    input wire i_irq_other,
    // Modem pins, active low, and the receive clock pin
    input wire i_dcd_n,
    input wire i_cts_n,
    input wire i_sync_n,
    input wire i_receive_clock_pin,
    // Outputs
    output reg o_sync_n,
    output reg o_sync_oe_n,
    output reg o_ext_irq,
    output reg o_int_pending
);

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    reg [3:0] meta_q;
    reg [3:0] pin_q;
    reg [3:0] pin_prev_q;
    wire dcd_n = pin_q[0];
    wire cts_n = pin_q[1];
    wire sync_n = pin_q[2];
    wire receive_clock_pin = pin_q[3];

    // Two stages per pin; logic reads pin_q, and pin_prev_q for the receive clock edge
    always @(posedge i_core_clk)
    begin
        meta_q <= {i_receive_clock_pin, i_sync_n, i_cts_n, i_dcd_n};
        pin_q <= meta_q;
        pin_prev_q <= pin_q;
    end

    // ==========================================================
    // Command decode
    // ==========================================================
    reg [2:0] ptr_q;
    wire cmd_rst_ext = i_cmd_wr &&
        i_cmd_data[`SCS_CMD_HI:`SCS_CMD_LO] == `SCS_CMD_RST_EXT;
    wire cmd_rst_urun = i_cmd_wr &&
        i_cmd_data[`SCS_URUN_HI:`SCS_URUN_LO] == `SCS_CMD_RST_URUN;

    // Pointer is single shot: it falls back to the status register
    always @(posedge i_core_clk)
    begin
        if (i_reset)
            ptr_q <= `SCS_PTR_STATUS;
        else if (i_cmd_wr)
            ptr_q <= i_cmd_data[2:0];
        else if (i_rd)
            ptr_q <= `SCS_PTR_STATUS;
    end

    // ==========================================================
    // Mode helpers and hunt state
    // ==========================================================
    wire m_async = i_rx_mode == `SCS_MODE_ASYNC;
    wire m_chsync = i_rx_mode == `SCS_MODE_CHSYNC;
    wire m_sdlc = i_rx_mode == `SCS_MODE_SDLC;
    wire m_ext = i_rx_mode == `SCS_MODE_EXTSYNC;
    wire sync_pin_in = m_async || m_ext;

    reg hunt_live_q;
    reg [3:0] ones_q;
    reg brk_live_q;
    reg brk_armed_q;

    // Internal hunt state for character sync and SDLC modes
    always @(posedge i_core_clk)
    begin
        if (i_reset)
            hunt_live_q <= 1'b1;
        else if (i_enter_hunt || (m_sdlc && !i_rx_enable))
            hunt_live_q <= 1'b1;
        else if (m_chsync && i_sync_pattern)
            hunt_live_q <= 1'b0;
        else if (m_sdlc && i_flag_seen)
            hunt_live_q <= 1'b0;
    end

    // Ones counter for abort detection in SDLC
    always @(posedge i_core_clk)
    begin
        if (i_reset || !m_sdlc)
            ones_q <= 4'h0;
        else if (i_rx_bit_valid)
        begin
            if (!i_rx_bit)
                ones_q <= 4'h0;
            else if (ones_q != 4'hF)
                ones_q <= ones_q + 4'h1;
        end
    end
    wire abort_now = ones_q >= `SCS_ABORT_ONES;

    // Break condition, re-armed only by the reset command
    always @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            brk_live_q <= 1'b0;
            brk_armed_q <= 1'b1;
        end
        else if (m_async)
        begin
            if (brk_armed_q && i_break_char)
            begin
                brk_live_q <= 1'b1;
                brk_armed_q <= 1'b0;
            end
            else if (brk_live_q && i_break_end)
                brk_live_q <= 1'b0;
            else if (cmd_rst_ext && !brk_live_q)
                brk_armed_q <= 1'b1;
        end
        else if (m_sdlc)
            brk_live_q <= abort_now;
        else
            brk_live_q <= 1'b0;
    end

    // ==========================================================
    // Live external/status values and latches
    // ==========================================================
    // Hunt: async/ext follow inverted pin; high pin holds it clear
    wire hunt_live = sync_pin_in ? !sync_n : hunt_live_q;

    wire [4:0] ext_live = {brk_live_q, 1'b0, !cts_n, hunt_live, !dcd_n};
    reg [4:0] ext_latch_q;
    reg urun_q;
    reg ext_irq_q;

    wire urun_set = i_tx_underrun && !urun_q;
    wire ext_change = (ext_live != ext_latch_q) || urun_set;

    // Latches freeze while an interrupt is outstanding; the reset
    // command reopens them, so a read right after sees live pins
    always @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            ext_latch_q <= 5'h0;
            ext_irq_q <= 1'b0;
        end
        else if (cmd_rst_ext)
        begin
            ext_latch_q <= ext_live;
            // An underrun in the clear cycle keeps its interrupt
            ext_irq_q <= urun_set;
        end
        else if (!ext_irq_q && ext_change)
        begin
            ext_latch_q <= ext_live;
            ext_irq_q <= 1'b1;
        end
    end

    // Underrun latch; a new underrun outranks its own clear
    always @(posedge i_core_clk)
    begin
        if (i_reset)
            urun_q <= 1'b1;
        else if (i_tx_underrun)
            urun_q <= 1'b1;
        else if (cmd_rst_urun)
            urun_q <= 1'b0;
    end

    // Transmit empty, held clear while CRC goes out
    reg txe_q;
    always @(posedge i_core_clk)
    begin
        if (i_reset)
            txe_q <= 1'b1;
        else
            txe_q <= i_tx_buf_empty && !i_tx_crc_sending;
    end

    wire ip = CHANNEL_B ? 1'b0 : (ext_irq_q || i_irq_other);

    wire [7:0] status = {ext_latch_q[4], urun_q, ext_latch_q[2],
        ext_latch_q[1], ext_latch_q[0], txe_q, ip,
        i_rx_queue_nonempty};

    // ==========================================================
    // Read mux and sync output pulse
    // ==========================================================
    reg [1:0] pulse_q;
    always @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            o_rd_data <= 8'h00;
            o_ext_irq <= 1'b0;
            o_int_pending <= 1'b0;
            pulse_q <= 2'h0;
            o_sync_n <= 1'b1;
            o_sync_oe_n <= 1'b1;
        end
        else
        begin
            case (ptr_q)
                `SCS_PTR_SPECIAL: o_rd_data <= i_special_receive_status;
                `SCS_PTR_VECTOR: o_rd_data <= CHANNEL_B ?
                    i_vector_readback : 8'h00;
                default: o_rd_data <= status;
            endcase
            o_ext_irq <= ext_irq_q;
            o_int_pending <= ip;
            if (m_chsync && i_sync_pattern)
                pulse_q <= `SCS_SYNC_PULSE;
            else if (pulse_q != 2'h0)
                pulse_q <= pulse_q - 2'h1;
            o_sync_n <= !(m_chsync && (i_sync_pattern ||
                pulse_q != 2'h0));
            o_sync_oe_n <= !m_chsync;
        end
    end

    // Receive clock rising edge is detected but unused; external sync follows the pin level
    wire rxc_rise = receive_clock_pin && !pin_prev_q[3];
    wire unused_ok = rxc_rise;

endmodule

// ==== verification/scs_channel_status_sva.sv ====
`timescale 1ns/1ps
// ====================
// Port checker
module scs_channel_status_sva #(
    parameter CHANNEL_B = 0
) (
    // Clock and reset
    input wire i_core_clk,
    input wire i_reset,
    // Host side
    input wire i_cmd_wr,
    input wire [7:0] i_cmd_data,
    input wire i_rd,
    input wire [7:0] i_special_receive_status,
    input wire [7:0] i_vector_readback,
    input wire [7:0] o_rd_data,
    // Line side and interrupts
    input wire [1:0] i_rx_mode,
    input wire i_sync_pattern,
    input wire i_irq_other,
    input wire o_sync_n,
    input wire o_sync_oe_n,
    input wire o_ext_irq,
    input wire o_int_pending
);
    // One clock domain for every check
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_reset);
    // Pointer reads land two edges after the write
    ptr_special_a:
    assert property (i_cmd_wr && i_cmd_data[2:0] == 3'h1 ##1 !i_cmd_wr
        && !i_rd |=> o_rd_data == $past(i_special_receive_status))
        else $error("special read wrong");
    ptr_vector_a:
    assert property (i_cmd_wr && i_cmd_data[2:0] == 3'h2 ##1 !i_cmd_wr
        && !i_rd |=> o_rd_data == (CHANNEL_B ? $past(i_vector_readback)
        : 8'h00)) else $error("vector read wrong");
    // A pending interrupt waits for a command write
    irq_hold_a:
    assert property (o_ext_irq && !i_cmd_wr && !$past(i_cmd_wr)
        |=> o_ext_irq) else $error("ext irq dropped early");
    sync_drive_a:
    assert property (i_rx_mode != 2'h1 && $past(i_rx_mode) != 2'h1
        |-> o_sync_oe_n) else $error("sync driven off mode");
    sync_pulse_a:
    assert property (i_rx_mode == 2'h1 && i_sync_pattern
        |-> ##[1:3] !o_sync_n) else $error("no sync pulse");
    pulse_len_a:
    assert property ($fell(o_sync_n) |=> !o_sync_n [*2])
        else $error("sync pulse short");
    pend_set_a:
    assert property (i_irq_other [*3] |-> o_int_pending || CHANNEL_B)
        else $error("pending not set");
    pend_clr_a:
    assert property ((!i_irq_other && !o_ext_irq) [*3] |-> !o_int_pending)
        else $error("pending not cleared");
endmodule

bind scs_channel_status scs_channel_status_sva #(.CHANNEL_B(CHANNEL_B))
    chk (.*);

// ==== verification/scs_line_model.sv ====
`timescale 1ns/1ps
// ====================
// External sync logic and receive clock
module scs_line_model (
    // Bench controls
    input wire logic i_run,
    input wire logic i_found,
    input wire logic i_lost,
    // Line pins
    output logic o_rxc,
    output logic o_sync_n
);
    // Sync held high until the pattern is found
    initial
    begin
        o_rxc = 1'h0;
        o_sync_n = 1'h1;
    end
    // Clock stands still outside frames
    always #80 o_rxc = i_run ? ~o_rxc : 1'h0;
    // Low on second rising edge, high only when told
    always @(posedge i_found)
    begin
        @(posedge o_rxc);
        @(posedge o_rxc);
        o_sync_n = 1'h0;
        @(posedge i_lost);
        o_sync_n = 1'h1;
    end
endmodule

// ==== verification/tb_scs_channel_status.sv ====
`timescale 1ns/1ps
`define CHK(n,e,s) begin cmp_count++; if ((s) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", n, e, s); end end
// ====================
// Bench
module tb_scs_channel_status;
    logic i_core_clk = '0, i_reset = '1, i_cmd_wr = '0, i_rd = '0;
    logic [7:0] i_cmd_data = '0, i_special_receive_status = 8'hA5;
    logic [7:0] i_vector_readback = 8'h5A, o_rd_data;
    logic [1:0] i_rx_mode = '0;
    logic i_rx_enable = '1, i_enter_hunt = '0, i_rx_queue_nonempty = '0;
    logic i_tx_buf_empty = '1, i_tx_crc_sending = '0, i_tx_underrun = '0;
    logic i_sync_pattern = '0, i_flag_seen = '0, i_rx_bit_valid = '0;
    logic i_rx_bit = '0, i_break_char = '0, i_break_end = '0;
    logic i_irq_other = '0, i_dcd_n = '1, i_cts_n = '1;
    logic run = '0, found = '0, lost = '0, i_receive_clock_pin, m_sync_n;
    logic o_sync_n, o_sync_oe_n, o_ext_irq, o_int_pending;
    wire i_sync_n = o_sync_oe_n ? m_sync_n : o_sync_n;
    int failures = 0, cmp_count = 0, cyc = 0;
    scs_line_model line (.i_run(run), .i_found(found), .i_lost(lost),
        .o_rxc(i_receive_clock_pin), .o_sync_n(m_sync_n));
    scs_channel_status #(.CHANNEL_B(0)) dut (.*);
    // Clock and hang guard
    always #5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk)
        if (++cyc == 5000)
        begin
            failures++;
            report_and_stop();
        end
    task report_and_stop;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task w(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    task automatic p(ref logic s);
        s = 1'h1;
        w(1);
        s = 1'h0;
    endtask
    task cw(input [7:0] c);
        i_cmd_data = c;
        i_cmd_wr = 1'h1;
        w(1);
        i_cmd_wr = 1'h0;
    endtask
    // Pointer 0 needs no write; wait covers pin synchronisers
    task st(input [7:0] m, e);
        w(8);
        `CHK("status", e, o_rd_data & m)
    endtask
    // Pointer read, then a read returns the pointer to 0
    task pr(input [7:0] c, e);
        cw(c);
        w(2);
        `CHK("pointer read", e, o_rd_data)
        p(i_rd);
    endtask
    task xr(input e);
        `CHK("ext irq", e, o_ext_irq)
        cw(8'h10);
        w(2);
    endtask
    // Find sync on the line, then lose it
    task ln(input [7:0] e);
        run = 1'h1;
        p(found);
        w(40);
        st(8'h10, e);
        xr(1'h1);
        p(lost);
        w(8);
        run = 1'h0;
    endtask
    initial
    begin
        w(20);
        i_reset = 1'h0;
        st(8'hC5, 8'h44);
        pr(8'h01, 8'hA5);
        pr(8'h02, 8'h00);
        i_rx_queue_nonempty = 1'h1;
        st(8'h01, 8'h01);
        i_rx_queue_nonempty = 1'h0;
        i_tx_crc_sending = 1'h1;
        st(8'h05, 8'h00);
        i_tx_crc_sending = 1'h0;
        st(8'h04, 8'h04);
        cw(8'hC0);
        st(8'h40, 8'h00);
        p(i_tx_underrun);
        st(8'h40, 8'h40);
        xr(1'h1);
        i_dcd_n = 1'h0;
        w(8);
        i_cts_n = 1'h0;
        st(8'h28, 8'h08);
        xr(1'h1);
        st(8'h28, 8'h28);
        xr(1'h0);
        i_irq_other = 1'h1;
        w(4);
        `CHK("int pending", 1'h1, o_int_pending)
        i_irq_other = 1'h0;
        w(2);
        `CHK("int idle", 1'h0, o_int_pending)
        p(i_break_char);
        st(8'h80, 8'h80);
        xr(1'h1);
        p(i_break_end);
        st(8'h80, 8'h00);
        xr(1'h1);
        ln(8'h10);
        st(8'h10, 8'h00);
        xr(1'h1);
        i_rx_mode = 2'h3;
        p(i_enter_hunt);
        st(8'h10, 8'h00);
        ln(8'h10);
        xr(1'h1);
        i_rx_mode = 2'h1;
        p(i_enter_hunt);
        st(8'h10, 8'h10);
        xr(1'h1);
        p(i_sync_pattern);
        `CHK("sync oe", 1'h0, o_sync_oe_n)
        `CHK("sync out", 1'h0, o_sync_n)
        st(8'h10, 8'h00);
        xr(1'h1);
        i_rx_mode = 2'h2;
        p(i_enter_hunt);
        st(8'h10, 8'h10);
        xr(1'h1);
        p(i_flag_seen);
        st(8'h10, 8'h00);
        xr(1'h1);
        i_rx_bit = 1'h1;
        i_rx_bit_valid = 1'h1;
        w(7);
        i_rx_bit_valid = 1'h0;
        st(8'h80, 8'h80);
        report_and_stop();
    end
endmodule
